// ==== hdl/balloon_dev.sv ====
// Device side of the memory balloon: configuration registers and page queues.
//
// Behaviour
// - Feature bit 0 asks the guest to announce pages before reusing them.
// - Feature bit 1 offers a third queue for guest memory statistics.
// - Feature bit 2 lets the guest shrink the balloon when memory runs out.
// - Refuse feature acceptance when offered tell-before-reuse was not accepted.
// - Legacy mode never refuses and allows reuse before the device is told; reuse_early stays low there if tell-before-reuse was accepted.
// - Config holds target count then current count, both 32-bit little-endian.
// - Legacy mode keeps both config fields little-endian too.
// - Inflate requests carry 32-bit page numbers of 4096-byte units.
// - Each inflate or deflate request is acknowledged by marking it used.
// - Device may claim a page as soon as it reads its number.
// - With tell-before-reuse, deflated pages stay claimed until acknowledged while the page store has room and legacy mode is off.
// - Queue 0 inflates, queue 1 deflates, queue 2 exists only with statistics; queue 2 entries are taken whether or not statistics were negotiated.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module balloon_dev
  import balloon_pkg::*;
#(
  parameter logic [2:0] DEV_FEATURES = 3'h7,
  parameter bit REFUSE_NO_TELL = 1'b1,
  parameter int STORE_DEPTH = 16,
  parameter int COUNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] target_value,
  input wire logic target_load,
  input wire logic legacy_mode,
  input wire logic req_valid,
  input wire logic [1:0] req_queue,
  input wire logic [31:0] req_page,
  input wire logic req_last,
  output logic req_ready,
  output logic used_valid,
  output logic [1:0] used_queue,
  output logic [COUNT_W-1:0] used_count,
  output logic page_valid,
  output logic [43:0] page_addr,
  output logic page_claim,
  output logic config_changed,
  output logic reuse_early
);

  localparam int AW = $clog2(STORE_DEPTH);
  localparam int FW = $clog2(STORE_DEPTH + 1);
  localparam logic [FW-1:0] FILL_FULL = FW'(STORE_DEPTH);

  // ==========================================================================
  // Configuration and negotiation registers.
  logic [31:0] target_r, target_nxt;
  logic [31:0] current_r, current_nxt;
  logic [2:0] drv_feat_r, drv_feat_nxt;
  logic [3:0] status_r, status_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic changed_r, changed_nxt;
  logic [31:0] held_r, held_nxt;
  logic reuse_r, reuse_nxt;
  logic [2:0] negotiated;
  logic refuse;

  // Features in force are those both sides agreed on.
  assign negotiated = DEV_FEATURES & drv_feat_r;
  // Outside legacy mode, acceptance fails when tell-before-reuse was offered but declined.
  assign refuse = REFUSE_NO_TELL && DEV_FEATURES[FEAT_TELL] && !drv_feat_r[FEAT_TELL]
                  && !legacy_mode;

  // Register writes, read mux and target loading.
  always_comb begin
    target_nxt = target_r;
    current_nxt = current_r;
    drv_feat_nxt = drv_feat_r;
    status_nxt = status_r;
    rdata_nxt = RST_WORD;
    changed_nxt = 1'b0;
    if (target_load) begin
      target_nxt = target_value;
      changed_nxt = (target_value != target_r);
    end
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CURRENT: current_nxt = reg_wdata;
        ADDR_DRV_FEAT: begin
          if (!status_r[STAT_FEATURE_ACCEPT]) begin
            drv_feat_nxt = reg_wdata[2:0];
          end
        end
        ADDR_STATUS: begin
          status_nxt = reg_wdata[3:0];
          status_nxt[STAT_FEATURE_ACCEPT] = reg_wdata[STAT_FEATURE_ACCEPT] && !refuse;
          if (reg_wdata[3:0] == RST_STATUS) begin
            drv_feat_nxt = RST_FEAT;
          end
        end
        default: ;
      endcase
    end
    // Word values go out with byte 0 on the low lane in every mode.
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_TARGET: rdata_nxt = target_r;
        ADDR_CURRENT: rdata_nxt = current_r;
        ADDR_DEV_FEAT: rdata_nxt = {29'h0000_0000, DEV_FEATURES};
        ADDR_DRV_FEAT: rdata_nxt = {29'h0000_0000, drv_feat_r};
        ADDR_STATUS: rdata_nxt = {28'h000_0000, status_r};
        ADDR_HELD: rdata_nxt = held_r;
        default: rdata_nxt = RST_WORD;
      endcase
    end
    // Early reuse holds once features are accepted without tell-before-reuse.
    reuse_nxt = status_nxt[STAT_FEATURE_ACCEPT]
                && !(DEV_FEATURES[FEAT_TELL] && drv_feat_nxt[FEAT_TELL]);
  end

  // ==========================================================================
  // Request engine state.
  state_t state_r, state_nxt;
  logic [1:0] cur_q_r, cur_q_nxt;
  logic [COUNT_W-1:0] cnt_r, cnt_nxt;
  logic [FW-1:0] fill_r, fill_nxt;
  logic [FW-1:0] ridx_r, ridx_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic ready_r, ready_nxt;
  logic used_r, used_nxt;
  logic [1:0] used_q_r, used_q_nxt;
  logic [COUNT_W-1:0] used_cnt_r, used_cnt_nxt;
  logic pv_r, pv_nxt;
  logic [43:0] pa_r, pa_nxt;
  logic pc_r, pc_nxt;
  logic take;
  logic hold_deflate;
  logic st_wr, st_rd;
  logic [31:0] st_rdata;

  assign take = req_valid && ready_r;
  // With tell-before-reuse and legacy mode off, deflated pages stay claimed until acknowledgement when room allows.
  assign hold_deflate = negotiated[FEAT_TELL] && !legacy_mode && (fill_r != FILL_FULL);
  assign st_wr = (state_r == S_TAKE) && take && (req_queue == Q_DEFLATE) && hold_deflate;
  assign st_rd = (state_r == S_REPLAY) && (ridx_r != fill_r);

  page_store #(
    .WIDTH(32),
    .DEPTH(STORE_DEPTH)
  ) u_store (
    .mclk(mclk),
    .wr_en(st_wr),
    .wr_addr(fill_r[AW-1:0]),
    .wr_data(req_page),
    .rd_en(st_rd),
    .rd_addr(ridx_r[AW-1:0]),
    .rd_data(st_rdata)
  );

  // Entry intake, acknowledgement and replay of held deflations.
  always_comb begin
    state_nxt = state_r;
    cur_q_nxt = cur_q_r;
    cnt_nxt = cnt_r;
    fill_nxt = fill_r;
    ridx_nxt = ridx_r;
    rd_pend_nxt = st_rd;
    held_nxt = held_r;
    used_nxt = 1'b0;
    used_q_nxt = used_q_r;
    used_cnt_nxt = used_cnt_r;
    pv_nxt = 1'b0;
    pa_nxt = pa_r;
    pc_nxt = pc_r;
    unique case (state_r)
      S_IDLE: begin
        if (status_r[STAT_DRIVER_OK]) begin
          state_nxt = S_TAKE;
        end
      end
      S_TAKE: begin
        if (!status_r[STAT_DRIVER_OK]) begin
          state_nxt = S_IDLE;
        end else if (take) begin
          cur_q_nxt = req_queue;
          cnt_nxt = cnt_r + COUNT_W'(1);
          unique case (req_queue)
            Q_INFLATE: begin
              // The page is claimed the moment its number is read.
              pv_nxt = 1'b1;
              pc_nxt = 1'b1;
              pa_nxt = {req_page, 12'h000};
              held_nxt = held_r + 32'h0000_0001;
            end
            Q_DEFLATE: begin
              if (hold_deflate) begin
                fill_nxt = fill_r + FW'(1);
              end else begin
                // Without tell-before-reuse the release is immediate.
                pv_nxt = 1'b1;
                pc_nxt = 1'b0;
                pa_nxt = {req_page, 12'h000};
                held_nxt = (held_r == RST_WORD) ? held_r : held_r - 32'h0000_0001;
              end
            end
            default: ;
          endcase
          if (req_last) begin
            cnt_nxt = '0;
            // Statistics buffers are kept, not used; other numbers are dropped.
            if (req_queue == Q_INFLATE || req_queue == Q_DEFLATE) begin
              state_nxt = S_ACK;
              used_cnt_nxt = cnt_r + COUNT_W'(1);
            end
          end
        end
      end
      S_ACK: begin
        // The request is marked used on its own queue.
        used_nxt = 1'b1;
        used_q_nxt = cur_q_r;
        ridx_nxt = '0;
        state_nxt = (fill_r != '0) ? S_REPLAY : S_TAKE;
      end
      S_REPLAY: begin
        if (st_rd) begin
          ridx_nxt = ridx_r + FW'(1);
        end
        // Held deflations are released only after the acknowledgement.
        if (rd_pend_r) begin
          pv_nxt = 1'b1;
          pc_nxt = 1'b0;
          pa_nxt = {st_rdata, 12'h000};
          held_nxt = (held_r == RST_WORD) ? held_r : held_r - 32'h0000_0001;
        end
        if (!st_rd && !rd_pend_r) begin
          fill_nxt = '0;
          state_nxt = S_TAKE;
        end
      end
    endcase
    // Entries are offered only while running and collecting.
    // The next status is used so that ready drops in the same edge as driver-running.
    ready_nxt = (state_nxt == S_TAKE) && status_nxt[STAT_DRIVER_OK] && (state_r != S_ACK);
  end

  // ==========================================================================
  // All registers of the block.
  always_ff @(posedge mclk) begin
    if (rst) begin
      target_r <= RST_WORD;
      current_r <= RST_WORD;
      drv_feat_r <= RST_FEAT;
      status_r <= RST_STATUS;
      rdata_r <= RST_WORD;
      changed_r <= 1'b0;
      reuse_r <= 1'b0;
      state_r <= S_IDLE;
      cur_q_r <= Q_INFLATE;
      cnt_r <= '0;
      fill_r <= '0;
      ridx_r <= '0;
      rd_pend_r <= 1'b0;
      held_r <= RST_WORD;
      ready_r <= 1'b0;
      used_r <= 1'b0;
      used_q_r <= Q_INFLATE;
      used_cnt_r <= '0;
      pv_r <= 1'b0;
      pa_r <= '0;
      pc_r <= 1'b0;
    end else begin
      target_r <= target_nxt;
      current_r <= current_nxt;
      drv_feat_r <= drv_feat_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      changed_r <= changed_nxt;
      reuse_r <= reuse_nxt;
      state_r <= state_nxt;
      cur_q_r <= cur_q_nxt;
      cnt_r <= cnt_nxt;
      fill_r <= fill_nxt;
      ridx_r <= ridx_nxt;
      rd_pend_r <= rd_pend_nxt;
      held_r <= held_nxt;
      ready_r <= ready_nxt;
      used_r <= used_nxt;
      used_q_r <= used_q_nxt;
      used_cnt_r <= used_cnt_nxt;
      pv_r <= pv_nxt;
      pa_r <= pa_nxt;
      pc_r <= pc_nxt;
    end
  end

  // Outputs come straight from registers.
  assign reg_rdata = rdata_r;
  assign req_ready = ready_r;
  assign used_valid = used_r;
  assign used_queue = used_q_r;
  assign used_count = used_cnt_r;
  assign page_valid = pv_r;
  assign page_addr = pa_r;
  assign page_claim = pc_r;
  assign config_changed = changed_r;
  assign reuse_early = reuse_r;

  // ==========================================================================
  // Checks and coverage.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_used_after_last: assert property (
    take && req_last && (req_queue == Q_INFLATE || req_queue == Q_DEFLATE)
    |-> ##2 used_valid && used_queue == $past(req_queue, 2))
    else $error("Request was not marked used two cycles after its last entry.");
  chk_accept_refused: assert property (
    reg_wr && reg_addr == ADDR_STATUS && refuse |=> !status_r[STAT_FEATURE_ACCEPT])
    else $error("Feature acceptance was granted although it had to be refused.");
  chk_inflate_claim: assert property (
    take && state_r == S_TAKE && req_queue == Q_INFLATE
    |=> page_valid && page_claim && page_addr == {$past(req_page), 12'h000})
    else $error("Inflated page was not claimed in the next cycle.");
  chk_deflate_held: assert property (
    st_wr |=> !page_valid ##1 (!$past(req_last, 2) || (used_valid && !page_valid)))
    else $error("Held deflated page was released before acknowledgement.");
  chk_stats_unused: assert property (
    take && state_r == S_TAKE && req_queue == Q_STATS && req_last |=> !used_valid [*3])
    else $error("A statistics buffer was marked used.");
  chk_ready_running: assert property (
    req_ready |-> status_r[STAT_DRIVER_OK] && state_r == S_TAKE)
    else $error("Entries were offered while the driver was not running.");
  chk_current_write: assert property (
    reg_wr && reg_addr == ADDR_CURRENT |=> current_r == $past(reg_wdata))
    else $error("Current page count did not take the written word.");
  chk_target_ro: assert property (
    reg_wr && reg_addr == ADDR_TARGET && !target_load |=> $stable(target_r))
    else $error("Target page count changed on a bus write.");
  chk_early_release: assert property (
    take && state_r == S_TAKE && req_queue == Q_DEFLATE && !negotiated[FEAT_TELL]
    |=> page_valid && !page_claim)
    else $error("Deflated page was not released at once without tell-before-reuse.");
  cov_inflate_ack: cover property (used_valid && used_queue == Q_INFLATE);
  cov_deflate_replay: cover property (state_r == S_REPLAY ##1 page_valid && !page_claim);
  cov_refused: cover property (reg_wr && reg_addr == ADDR_STATUS && refuse);

endmodule

// ==== hdl/balloon_pkg.sv ====
// Constants shared by the memory balloon page exchange block.
package balloon_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one 32-bit word each).
  localparam logic [7:0] ADDR_TARGET = 8'h00;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_DEV_FEAT = 8'h08;
  localparam logic [7:0] ADDR_DRV_FEAT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_HELD = 8'h14;

  // ==========================================================================
  // Feature bit positions.
  localparam int FEAT_TELL = 0;
  localparam int FEAT_STATS = 1;
  localparam int FEAT_SHRINK = 2;

  // Device status bit positions.
  localparam int STAT_DRIVER_OK = 2;
  localparam int STAT_FEATURE_ACCEPT = 3;

  // ==========================================================================
  // Queue numbers.
  localparam logic [1:0] Q_INFLATE = 2'h0;
  localparam logic [1:0] Q_DEFLATE = 2'h1;
  localparam logic [1:0] Q_STATS = 2'h2;

  // Page numbers count 4096-byte units whatever the guest page size.
  localparam int PAGE_SHIFT = 12;

  // Values after reset.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [2:0] RST_FEAT = 3'h0;

  // Request engine states.
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TAKE = 2'b01,
    S_ACK = 2'b10,
    S_REPLAY = 2'b11
  } state_t;

endpackage

// ==== hdl/page_store.sv ====
// Small memory that keeps deflated page numbers until the request is acknowledged.
`timescale 1ns/1ns
module page_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================================
  // Write port and registered read port.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ==== testbench/guest_fetch_model.sv ====
// Guest side model that offers descriptor entries to the balloon block.
`timescale 1ns/1ns
module guest_fetch_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic [1:0] queue,
  input wire logic [7:0] count,
  input wire logic [31:0] base,
  input wire logic req_ready,
  output logic req_valid,
  output logic [1:0] req_queue,
  output logic [31:0] req_page,
  output logic req_last,
  output logic done
);
  logic [7:0] left;
  initial begin
    req_valid = 1'b0;
    req_queue = 2'h0;
    req_page = 32'h0000_0000;
    req_last = 1'b0;
    done = 1'b0;
    left = 8'h00;
  end
  // Each entry stays offered until taken; an idle page line scrambles.
  always @(posedge mclk) begin
    done <= 1'b0;
    if (start) begin
      req_valid <= 1'b1;
      req_queue <= queue;
      req_page <= base;
      req_last <= (count == 8'h01);
      left <= count;
    end else if (req_valid && req_ready) begin
      if (req_last) begin
        req_valid <= 1'b0;
        req_page <= ~req_page;
        done <= 1'b1;
      end else begin
        req_page <= req_page + 32'h0000_0001;
        req_last <= (left == 8'h02);
        left <= left - 8'h01;
      end
    end else if (!req_valid) begin
      req_page <= ~req_page;
    end
  end
endmodule

// ==== testbench/memory_balloon_page_exchange_bench.sv ====
// Self-checking bench for the memory balloon page exchange block.
`timescale 1ns/1ns
module memory_balloon_page_exchange_bench
  import balloon_pkg::*;
;
  logic mclk, rst, reg_wr, reg_rd, target_load, legacy_mode, start;
  logic req_valid, req_last, req_ready, used_valid, page_valid, page_claim;
  logic config_changed, reuse_early, f_done, seen;
  logic [7:0] reg_addr, f_count;
  logic [31:0] reg_wdata, reg_rdata, target_value, f_base, req_page, d;
  logic [1:0] f_queue, req_queue, used_queue;
  logic [15:0] used_count;
  logic [43:0] page_addr;
  logic [44:0] pq[$];
  logic [17:0] uq[$];
  int pc[$];
  int cyc, ucyc, n_mismatch, total_checks;

  balloon_dev balloon_dev_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .target_value(target_value), .target_load(target_load), .legacy_mode(legacy_mode),
    .req_valid(req_valid), .req_queue(req_queue), .req_page(req_page),
    .req_last(req_last), .req_ready(req_ready), .used_valid(used_valid),
    .used_queue(used_queue), .used_count(used_count), .page_valid(page_valid),
    .page_addr(page_addr), .page_claim(page_claim), .config_changed(config_changed),
    .reuse_early(reuse_early));
  guest_fetch_model guest_fetch_model_inst (.mclk(mclk), .start(start),
    .queue(f_queue), .count(f_count), .base(f_base), .req_ready(req_ready),
    .req_valid(req_valid), .req_queue(req_queue), .req_page(req_page),
    .req_last(req_last), .done(f_done));

  // ==========================================================================
  // Clock and event capture.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Page and used events are logged with the cycle they appeared in.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (page_valid === 1'b1) begin
      pq.push_back({page_claim, page_addr});
      pc.push_back(cyc);
    end
    if (used_valid === 1'b1) begin
      uq.push_back({used_queue, used_count});
      ucyc <= cyc;
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [44:0] e, input logic [44:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(nm, 45'(e), 45'(d));
  endtask
  // Offers one descriptor of n entries starting at page 0x100.
  task automatic run(input logic [1:0] q, input logic [7:0] n);
    pq.delete();
    pc.delete();
    uq.delete();
    @(posedge mclk);
    f_queue <= q;
    f_count <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int i = 0; i < 100 && f_done !== 1'b1; i++) @(posedge mclk) #1;
    repeat (8 + n) @(posedge mclk);
  endtask
  // Order 1 wants releases after the used pulse, 2 before it.
  task automatic pages(input logic cl, input int n, input logic [1:0] q, input int order);
    chk("page count", 45'(n), 45'(pq.size()));
    chk("used", 45'({q, 16'(n)}), 45'(uq.size() == 1 ? uq[0] : 18'h0_0000));
    for (int i = 0; i < n && i < pq.size(); i++) begin
      chk("page", {cl, 32'h0000_0100 + 32'(i), 12'h000}, pq[i]);
      if (order == 1) chk("after ack", 45'h1, 45'(pc[i] > ucyc));
      if (order == 2) chk("before ack", 45'h1, 45'(pc[i] < ucyc));
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    rchk("target reset", ADDR_TARGET, RST_WORD);
    rchk("features", ADDR_DEV_FEAT, 32'h0000_0007);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    wr(ADDR_CURRENT, 32'h0403_0201);
    rchk("current", ADDR_CURRENT, 32'h0403_0201);
    wr(ADDR_TARGET, 32'h0000_0009);
    rchk("target ro", ADDR_TARGET, RST_WORD);
    @(posedge mclk);
    target_value <= 32'h0000_1234;
    target_load <= 1'b1;
    @(posedge mclk);
    target_load <= 1'b0;
    #1 seen = (config_changed === 1'b1);
    repeat (4) @(posedge mclk) #1 seen |= (config_changed === 1'b1);
    chk("changed", 45'h1, 45'(seen));
    rchk("target", ADDR_TARGET, 32'h0000_1234);
    $display("t_regs done");
  endtask
  task automatic t_negot;
    wr(ADDR_DRV_FEAT, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_0008);
    rchk("refused", ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_DRV_FEAT, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0008);
    rchk("accepted", ADDR_STATUS, 32'h0000_0008);
    chk("reuse early", 45'h0, 45'(reuse_early));
    wr(ADDR_STATUS, 32'h0000_000C);
    $display("t_negot done");
  endtask
  task automatic t_flow;
    run(Q_INFLATE, 8'h03);
    pages(1'b1, 3, Q_INFLATE, 0);
    wr(ADDR_CURRENT, 32'h0000_0003);
    rchk("current after ack", ADDR_CURRENT, 32'h0000_0003);
    run(Q_DEFLATE, 8'h02);
    pages(1'b0, 2, Q_DEFLATE, 1);
    rchk("held", ADDR_HELD, 32'h0000_0001);
    run(Q_STATS, 8'h01);
    chk("stats used", 45'h0, 45'(uq.size() + pq.size()));
    $display("t_flow done");
  endtask
  task automatic t_legacy;
    @(posedge mclk);
    legacy_mode <= 1'b1;
    wr(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_DRV_FEAT, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_0008);
    rchk("legacy accept", ADDR_STATUS, 32'h0000_0008);
    chk("legacy reuse", 45'h1, 45'(reuse_early));
    wr(ADDR_STATUS, 32'h0000_000C);
    run(Q_DEFLATE, 8'h01);
    pages(1'b0, 1, Q_DEFLATE, 2);
    rchk("legacy held", ADDR_HELD, 32'h0000_0000);
    wr(ADDR_CURRENT, 32'h0403_0201);
    rchk("legacy le", ADDR_CURRENT, 32'h0403_0201);
    $display("t_legacy done");
  endtask

  // ==========================================================================
  // Main sequence, watchdog and verdict.
  task automatic close_out;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, reg_wr, reg_rd, target_load, legacy_mode, start} = 6'h20;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    target_value = 32'h0000_0000;
    f_queue = 2'h0;
    f_count = 8'h01;
    f_base = 32'h0000_0100;
    {cyc, ucyc, n_mismatch, total_checks} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_negot;
    t_flow;
    t_legacy;
    close_out;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    close_out;
  end
endmodule
